// >>> rps_top.sv
// Repeater port statistics: per-port counters and records, interrupt
// routing, active-port status and the management serial stream.
// Assumes events are one-cycle pulses and line symbols arrive as pairs.
//
// How it works
// [R1] Every port owns its own event counter and event record.
// [R2] A counter steps once per occurrence of the one event its select picks.
// [R3] A counter reaching the selected threshold raises an interrupt event.
// [R4] The record is one byte that logs up to eight distinct events.
// [R5] Each record bit can be masked so that its event is not logged.
// [R6] Every unmasked record event raises an interrupt event.
// [R7] Status, record and counter events go to the real-time or main line.
// [R8] The source port of activity is shown without polling every port.
// [R9] The management output repeats the packet then that packet's status.
// [R10] Exactly seven status bytes follow the last packet bit.
// [R11] The status bytes carry the interframe gap before the packet.
// [R12] Compression drops the data field except for frames to our address.
// [R13] The receiver then stores only status and header, 21 bytes a packet.
// [R14] Packet data is decoded from Manchester to serial NRZ form.
`timescale 1ns/1ps
module rps_top import rps_pkg::*; #(
    parameter int NPORTS = RPS_NPORTS
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // Per-port event pulses and activity levels
    input  wire logic [NPORTS*RPS_NEVT-1:0]  port_evt,
    input  wire logic [NPORTS-1:0]           port_active,
    // Statistics settings
    input  wire logic [RPS_SEL_W-1:0]        cnt_sel,
    input  wire logic [1:0]                  thresh_sel,
    input  wire logic [RPS_REC_W-1:0]        rec_mask,
    input  wire logic [RPS_NSRC-1:0]         irq_route_rt,
    input  wire logic [RPS_NSRC-1:0]         irq_enable,
    input  wire logic [RPS_NSRC-1:0]         irq_ack,
    // Interrupt lines
    output logic                             realtime_event_irq,
    output logic                             main_irq,
    output logic [RPS_NSRC-1:0]              irq_pending,
    // Per-port readout
    input  wire logic                        rd_req,
    input  wire logic                        rd_clear,
    input  wire logic [RPS_PORT_W-1:0]       rd_port,
    output logic                             rd_valid,
    output logic [RPS_CNT_W-1:0]             rd_count,
    output logic [RPS_REC_W-1:0]             rd_record,
    // Activity source status
    output logic [NPORTS-1:0]                act_map,
    output logic [RPS_PORT_W-1:0]            act_port,
    output logic                             act_any,
    // Repeated packet in Manchester symbol pairs
    input  wire logic                        mch_valid,
    input  wire logic [1:0]                  mch_pair,
    input  wire logic [RPS_PORT_W-1:0]       rx_src_port,
    output logic                             mch_ready,
    // Management receiver side
    input  wire logic                        compress_req,
    input  wire logic [47:0]                 own_addr,
    input  wire logic                        mgmt_stall,
    output logic                             mgmt_frame,
    output logic                             mgmt_bit_valid,
    output logic                             mgmt_data
);
    localparam int LVL_W = $clog2(RPS_FIFO_DEPTH+1);

    function automatic logic [NPORTS-1:0] port_onehot(
        input logic [RPS_PORT_W-1:0] p);
        logic [NPORTS-1:0] v;
        v = '0;
        if (int'(p) < NPORTS) v[p] = 1'b1;
        return v;
    endfunction

    function automatic logic [RPS_PORT_W-1:0] lowest_set(
        input logic [NPORTS-1:0] m);
        logic [RPS_PORT_W-1:0] r;
        r = '0;
        for (int i = NPORTS - 1; i >= 0; i--) begin
            if (m[i]) r = RPS_PORT_W'(i);
        end
        return r;
    endfunction

    // Per-port statistics
    logic [RPS_CNT_W-1:0] cnt_all [NPORTS];
    logic [RPS_REC_W-1:0] rec_all [NPORTS];
    logic [NPORTS-1:0]    cnt_hit;
    logic [NPORTS-1:0]    rec_hit;
    logic [NPORTS-1:0]    port_clr;

    assign port_clr = (rd_req && rd_clear) ? port_onehot(rd_port) : '0;

    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        rps_evt_port u_port ( // R1
            .sys_clk    (sys_clk),
            .rst        (rst),
            .evt        (port_evt[p*RPS_NEVT +: RPS_NEVT]),
            .cnt_sel    (cnt_sel),
            .thresh_sel (thresh_sel),
            .rec_mask   (rec_mask),
            .clr        (port_clr[p]),
            .cnt_q      (cnt_all[p]),
            .rec_q      (rec_all[p]),
            .cnt_hit_q  (cnt_hit[p]),
            .rec_hit_q  (rec_hit[p])
        );
    end

    // Readout
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_valid  <= 1'b0;
            rd_count  <= '0;
            rd_record <= '0;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_count  <= (int'(rd_port) < NPORTS) ? cnt_all[rd_port] : '0;
                rd_record <= (int'(rd_port) < NPORTS) ? rec_all[rd_port] : '0;
            end
        end
    end

    // Activity source status
    logic act_rise;
    // A port going active is the status interrupt source
    assign act_rise = |(port_active & ~act_map);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            act_map  <= '0;
            act_port <= '0;
            act_any  <= 1'b0;
        end else begin
            act_map <= port_active; // R8
            act_any <= |port_active; // R8
            // Holds the last source after activity ends
            if (|port_active) act_port <= lowest_set(port_active); // R8
        end
    end

    // Interrupt pending flags and routing
    logic [RPS_NSRC-1:0] pend_q;
    logic [RPS_NSRC-1:0] src_evt;
    logic                rt_irq_q;
    logic                main_irq_q;

    always_comb begin
        src_evt               = '0;
        src_evt[RPS_SRC_STAT] = act_rise;
        src_evt[RPS_SRC_CNT]  = |cnt_hit; // R3
        src_evt[RPS_SRC_REC]  = |rec_hit; // R6
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_q     <= '0;
            rt_irq_q   <= 1'b0;
            main_irq_q <= 1'b0;
        end else begin
            // A new event wins over an acknowledge in the same cycle
            pend_q     <= (pend_q & ~irq_ack) | (src_evt & irq_enable);
            rt_irq_q   <= |(pend_q & irq_route_rt); // R7
            main_irq_q <= |(pend_q & ~irq_route_rt); // R7
        end
    end

    // Manchester decode and frame tracking
    rps_rx_state_t       rx_q;
    logic                sym_ok;
    logic                sym_bit;
    logic                sym_take;
    logic [7:0]          byte_sh_q;
    logic [2:0]          bit_cnt_q;
    logic [RPS_LEN_W-1:0] len_q;
    logic [RPS_IFG_W-1:0] gap_q;
    logic [RPS_IFG_W-1:0] ifg_q;
    logic                comp_q;
    logic                own_q;
    logic                odd_q;
    logic [RPS_PORT_W-1:0] src_q;
    logic [2:0]          stat_idx_q;
    logic [7:0]          new_byte;
    logic                byte_done;
    logic                keep_byte;
    logic                mch_ready_q;
    logic                fifo_in_ready;

    assign sym_ok   = mch_pair == RPS_MCH_ONE || mch_pair == RPS_MCH_ZERO;
    assign sym_bit  = mch_pair == RPS_MCH_ONE; // R14
    assign sym_take = mch_valid && mch_ready_q;
    assign new_byte = {sym_bit, byte_sh_q[7:1]};
    assign byte_done = sym_take && sym_ok && rx_q == RPS_RX_FRAME &&
                       bit_cnt_q == 3'h7;
    // Payload kept unless compressing a frame not sent to us
    assign keep_byte = (int'(len_q) < RPS_HDR_BYTES) || !comp_q ||
                       own_q; // R12

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_q       <= RPS_RX_IDLE;
            byte_sh_q  <= '0;
            bit_cnt_q  <= '0;
            len_q      <= '0;
            comp_q     <= 1'b0;
            own_q      <= 1'b1;
            odd_q      <= 1'b0;
            src_q      <= '0;
            stat_idx_q <= '0;
        end else begin
            unique case (rx_q)
                RPS_RX_IDLE: begin
                    if (sym_take && sym_ok) begin
                        rx_q      <= RPS_RX_FRAME;
                        byte_sh_q <= new_byte;
                        bit_cnt_q <= 3'h1;
                        len_q     <= '0;
                        comp_q    <= compress_req; // R12
                        own_q     <= 1'b1;
                        src_q     <= rx_src_port;
                    end
                end
                RPS_RX_FRAME: begin
                    if (sym_take && sym_ok) begin
                        byte_sh_q <= new_byte;
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                        if (bit_cnt_q == 3'h7) begin
                            len_q <= len_q + 1'b1;
                            if (int'(len_q) < RPS_DA_BYTES &&
                                new_byte != own_addr[8*len_q[2:0] +: 8])
                                own_q <= 1'b0; // R12
                        end
                    end else if (sym_take) begin
                        // A code violation ends the frame
                        rx_q       <= RPS_RX_STAT;
                        odd_q      <= bit_cnt_q != 3'h0;
                        stat_idx_q <= '0;
                    end
                end
                RPS_RX_STAT: begin
                    if (fifo_in_ready) begin
                        stat_idx_q <= stat_idx_q + 1'b1;
                        if (int'(stat_idx_q) == RPS_STAT_BYTES - 1)
                            rx_q <= RPS_RX_IDLE; // R10
                    end
                end
                default: rx_q <= RPS_RX_IDLE;
            endcase
        end
    end

    // Gap: idle cycles before frame start, saturating
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gap_q <= '0;
            ifg_q <= '0;
        end else if (rx_q == RPS_RX_IDLE) begin
            if (sym_take && sym_ok) begin
                ifg_q <= gap_q; // R11
                gap_q <= '0;
            end else if (gap_q != '1) begin
                gap_q <= gap_q + 1'b1; // R11
            end
        end
    end

    // Status byte and FIFO feed
    logic [7:0]            stat_byte;
    logic [7:0]            stat_flags;
    logic                  fifo_in_valid;
    logic [RPS_FIFO_W-1:0] fifo_in_data;
    logic                  fifo_out_valid;
    logic                  fifo_out_ready;
    logic [RPS_FIFO_W-1:0] fifo_out_data;
    logic [LVL_W-1:0]      fifo_level;

    assign stat_flags = (comp_q ? RPS_FLAG_COMP : 8'h00) |
                        (own_q ? RPS_FLAG_OWN : 8'h00) |
                        (odd_q ? RPS_FLAG_ODD : 8'h00) |
                        (ifg_q == '1 ? RPS_FLAG_IFGSAT : 8'h00);

    always_comb begin
        unique case (stat_idx_q)
            3'h0:    stat_byte = 8'(src_q);
            3'h1:    stat_byte = ifg_q[7:0]; // R11
            3'h2:    stat_byte = ifg_q[15:8]; // R11
            3'h3:    stat_byte = len_q[7:0];
            3'h4:    stat_byte = len_q[15:8];
            3'h5:    stat_byte = (int'(src_q) < NPORTS) ? rec_all[src_q] : 8'h00;
            default: stat_byte = stat_flags;
        endcase
    end

    always_comb begin
        if (rx_q == RPS_RX_STAT) begin
            fifo_in_valid = 1'b1; // R9
            fifo_in_data  = {int'(stat_idx_q) == RPS_STAT_BYTES - 1,
                             stat_byte}; // R10
        end else begin
            fifo_in_valid = byte_done && keep_byte; // R12
            fifo_in_data  = {1'b0, new_byte}; // R9
        end
    end

    // Registered ready keeps a slot spare for its one-cycle lag
    always_ff @(posedge sys_clk) begin
        if (rst) mch_ready_q <= 1'b0;
        else mch_ready_q <= rx_q != RPS_RX_STAT &&
            int'(fifo_level) < RPS_FIFO_DEPTH - 1;
    end

    rps_fifo #(
        .WIDTH (RPS_FIFO_W),
        .DEPTH (RPS_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // Management serializer, LSB first NRZ
    logic [7:0] sh_q;
    logic [3:0] left_q;
    logic       sh_last_q;
    logic       emit;
    logic       frame_q;
    logic       bit_valid_q;
    logic       data_q;
    logic       end_q;

    assign emit = left_q != 4'h0 && !mgmt_stall;
    assign fifo_out_ready = left_q == 4'h0 || (left_q == 4'h1 && emit);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sh_q      <= '0;
            left_q    <= '0;
            sh_last_q <= 1'b0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            sh_q      <= fifo_out_data[7:0];
            left_q    <= 4'h8;
            sh_last_q <= fifo_out_data[8];
        end else if (emit) begin
            sh_q   <= {1'b0, sh_q[7:1]};
            left_q <= left_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            frame_q     <= 1'b0;
            bit_valid_q <= 1'b0;
            data_q      <= 1'b0;
            end_q       <= 1'b0;
        end else begin
            bit_valid_q <= emit; // R14
            if (emit) data_q <= sh_q[0]; // R9
            // Frame drops after the last status bit, not with it
            end_q <= emit && left_q == 4'h1 && sh_last_q;
            if (emit) frame_q <= 1'b1;
            else if (end_q) frame_q <= 1'b0; // R10
        end
    end

    assign realtime_event_irq = rt_irq_q;
    assign main_irq           = main_irq_q;
    assign irq_pending        = pend_q;
    assign mch_ready          = mch_ready_q;
    assign mgmt_frame         = frame_q;
    assign mgmt_bit_valid     = bit_valid_q;
    assign mgmt_data          = data_q;
endmodule // rps_top

// >>> rps_pkg.sv
// Shared constants and types of the repeater port statistics block.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package rps_pkg;
    localparam int RPS_NPORTS     = 12;
    localparam int RPS_PORT_W     = 4;
    localparam int RPS_NEVT       = 11;
    localparam int RPS_SEL_W      = 4;
    localparam int RPS_REC_W      = 8;
    localparam int RPS_CNT_W      = 16;
    localparam int RPS_IFG_W      = 16;
    localparam int RPS_LEN_W      = 16;
    localparam int RPS_STAT_BYTES = 7;
    localparam int RPS_DA_BYTES   = 6;
    localparam int RPS_HDR_BYTES  = 14;
    localparam int RPS_FIFO_DEPTH = 8;
    localparam int RPS_FIFO_W     = 9;
    localparam int RPS_NSRC       = 3;
    localparam int RPS_SRC_STAT   = 0;
    localparam int RPS_SRC_CNT    = 1;
    localparam int RPS_SRC_REC    = 2;
    localparam logic [1:0] RPS_MCH_ONE  = 2'h1;
    localparam logic [1:0] RPS_MCH_ZERO = 2'h2;
    localparam logic [RPS_CNT_W-1:0] RPS_THRESH [4] = '{
        16'h0010, 16'h0040, 16'h0100, 16'h0400};
    localparam logic [7:0] RPS_FLAG_COMP  = 8'h01;
    localparam logic [7:0] RPS_FLAG_OWN   = 8'h02;
    localparam logic [7:0] RPS_FLAG_ODD   = 8'h04;
    localparam logic [7:0] RPS_FLAG_IFGSAT = 8'h08;

    typedef enum logic [2:0] {
        RPS_RX_IDLE  = 3'h1,
        RPS_RX_FRAME = 3'h2,
        RPS_RX_STAT  = 3'h4
    } rps_rx_state_t;
endpackage

// >>> rps_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; level shows occupancy.
`timescale 1ns/1ps
module rps_fifo import rps_pkg::*; #(
    parameter int WIDTH = RPS_FIFO_W,
    parameter int DEPTH = RPS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // Fill side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    // Drain side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    // Occupancy
    output logic [$clog2(DEPTH+1)-1:0]    level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0]           mem_q [DEPTH];
    logic [AW-1:0]              wr_q;
    logic [AW-1:0]              rd_q;
    logic [$clog2(DEPTH+1)-1:0] cnt_q;
    logic                       push;
    logic                       pop;

    assign in_ready  = cnt_q != DEPTH[$clog2(DEPTH+1)-1:0];
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            // Pointers wrap on a power-of-two depth
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule // rps_fifo

// >>> rps_evt_port.sv
// One port's event counter and byte-wide event record.
// Assumes event inputs are one-cycle pulses from the port logic.
`timescale 1ns/1ps
module rps_evt_port import rps_pkg::*; (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Events and settings
    input  wire logic [RPS_NEVT-1:0]   evt,
    input  wire logic [RPS_SEL_W-1:0]  cnt_sel,
    input  wire logic [1:0]            thresh_sel,
    input  wire logic [RPS_REC_W-1:0]  rec_mask,
    // Clears from readout
    input  wire logic                  clr,
    // State and event hits
    output logic [RPS_CNT_W-1:0]       cnt_q,
    output logic [RPS_REC_W-1:0]       rec_q,
    output logic                       cnt_hit_q,
    output logic                       rec_hit_q
);
    logic                 cnt_inc;
    logic [RPS_REC_W-1:0] rec_set;

    // Selects beyond the event list count nothing
    assign cnt_inc = (int'(cnt_sel) < RPS_NEVT) ? evt[cnt_sel] : 1'b0; // R2
    assign rec_set = evt[RPS_REC_W-1:0] & ~rec_mask; // R5

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q     <= '0;
            cnt_hit_q <= 1'b0;
        end else begin
            // An event in the clear cycle counts as the first of the new run
            if (clr) cnt_q <= {{(RPS_CNT_W-1){1'b0}}, cnt_inc}; // R2
            else if (cnt_inc) cnt_q <= cnt_q + 1'b1; // R2
            cnt_hit_q <= cnt_inc && !clr &&
                (cnt_q + 1'b1 == RPS_THRESH[thresh_sel]); // R3
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rec_q     <= '0;
            rec_hit_q <= 1'b0;
        end else begin
            rec_q     <= (clr ? '0 : rec_q) | rec_set; // R4
            rec_hit_q <= |rec_set; // R6
        end
    end
endmodule // rps_evt_port

// >>> rps_top_properties.sv
// Port checker for rps_top: readout, activity, interrupt lines, stream.
// Bound from tb; one clock domain with synchronous reset.
`timescale 1ns/1ps
module rps_top_properties import rps_pkg::*; #(
    parameter int NPORTS = RPS_NPORTS
) (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // Watched ports
    input wire logic [NPORTS-1:0]     port_active,
    input wire logic [RPS_NSRC-1:0]   irq_route_rt,
    input wire logic [RPS_NSRC-1:0]   irq_ack,
    input wire logic [RPS_NSRC-1:0]   irq_pending,
    input wire logic                  realtime_event_irq,
    input wire logic                  main_irq,
    input wire logic                  rd_req,
    input wire logic [RPS_PORT_W-1:0] rd_port,
    input wire logic                  rd_valid,
    input wire logic [RPS_CNT_W-1:0]  rd_count,
    input wire logic [RPS_REC_W-1:0]  rd_record,
    input wire logic [NPORTS-1:0]     act_map,
    input wire logic                  act_any,
    input wire logic                  mgmt_stall,
    input wire logic                  mgmt_frame,
    input wire logic                  mgmt_bit_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_rd_ans;
        ##1 rd_valid;
    endsequence
    a_read_answer: assert property (rd_req |-> s_rd_ans)
        else $error("read not answered");
    a_read_cause: assert property (rd_valid |-> $past(rd_req))
        else $error("read answer without request");
    a_read_range: assert property (rd_req && rd_port >= NPORTS
        |=> rd_count == '0 && rd_record == '0)
        else $error("absent port read nonzero");
    a_act_copy: assert property (!$past(rst) |->
        act_map == $past(port_active) && act_any == (|$past(port_active)))
        else $error("activity status wrong");
    a_rt_line: assert property (!$past(rst) |-> realtime_event_irq ==
        (|($past(irq_pending) & $past(irq_route_rt))))
        else $error("real-time line wrong");
    a_main_line: assert property (!$past(rst) |-> main_irq ==
        (|($past(irq_pending) & ~$past(irq_route_rt))))
        else $error("main line wrong");
    a_pend_hold: assert property (!$past(rst) |->
        ($past(irq_pending) & ~$past(irq_ack) & ~irq_pending) == '0)
        else $error("pending lost without ack");
    a_bit_frame: assert property (mgmt_bit_valid |-> mgmt_frame)
        else $error("bit outside frame");
    a_frame_start: assert property ($rose(mgmt_frame) |-> mgmt_bit_valid)
        else $error("frame rose without bit");
    a_stall_hold: assert property (mgmt_stall |=> !mgmt_bit_valid)
        else $error("bit sent during stall");
endmodule // rps_top_properties

// >>> rps_mgmt_rx.sv
// Management receiver model: collects stream bytes LSB first.
// Assumes the block's clock; slow mode stalls every other cycle.
`timescale 1ns/1ps
module rps_mgmt_rx (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Stream from the block
    input  wire logic mgmt_frame,
    input  wire logic mgmt_bit_valid,
    input  wire logic mgmt_data,
    // Test controls
    input  wire logic slow,
    input  wire logic compress,
    // Towards the block
    output logic      compress_req,
    output logic      mgmt_stall
);
    logic [7:0] sh_q;
    logic [2:0] nb_q;
    logic       fr_q;
    logic [7:0] fb[$];
    int         done_q;
    assign compress_req = compress;
    always_ff @(posedge sys_clk) begin
        fr_q <= mgmt_frame;
        mgmt_stall <= rst ? 1'b0 : slow & ~mgmt_stall;
        if (rst) begin
            nb_q <= '0;
            done_q <= 0;
        end else begin
            if (mgmt_bit_valid) begin
                sh_q <= {mgmt_data, sh_q[7:1]};
                nb_q <= nb_q + 3'h1;
                if (nb_q == 3'h7) fb.push_back({mgmt_data, sh_q[7:1]});
            end
            if (fr_q && !mgmt_frame) done_q <= done_q + 1;
        end
    end
endmodule // rps_mgmt_rx

// >>> tb.sv
// Testbench for rps_top with the management receiver model.
// Assumes 200 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
module tb;
    import rps_pkg::*;
    logic sys_clk, rst = 1, rd_req = 0, rd_clear = 0, mch_valid = 0;
    logic [12*RPS_NEVT-1:0] port_evt = '0;
    logic [11:0] port_active = '0, act_map;
    logic [3:0] cnt_sel = '0, rd_port = '0, rx_src_port = '0, act_port;
    logic [1:0] thresh_sel = '0, mch_pair = '0;
    logic [7:0] rec_mask = '0, rd_record;
    logic [2:0] irq_route_rt = '0, irq_enable = '0, irq_ack = '0, irq_pending;
    logic [15:0] rd_count;
    logic [47:0] own_addr = 48'h0000_0000_0001;
    logic slow = 0, compress = 0, compress_req, mgmt_stall, mgmt_frame;
    logic realtime_event_irq, main_irq, rd_valid, act_any, mch_ready;
    logic mgmt_bit_valid, mgmt_data;
    int error_cnt = 0, num_checks = 0;
    rps_top rps_top_inst (.sys_clk, .rst, .port_evt, .port_active, .cnt_sel,
        .thresh_sel, .rec_mask, .irq_route_rt, .irq_enable, .irq_ack,
        .realtime_event_irq, .main_irq, .irq_pending, .rd_req, .rd_clear,
        .rd_port, .rd_valid, .rd_count, .rd_record, .act_map, .act_port,
        .act_any, .mch_valid, .mch_pair, .rx_src_port, .mch_ready,
        .compress_req, .own_addr, .mgmt_stall, .mgmt_frame, .mgmt_bit_valid,
        .mgmt_data);
    rps_mgmt_rx rps_mgmt_rx_inst (.sys_clk, .rst, .mgmt_frame,
        .mgmt_bit_valid, .mgmt_data, .slow, .compress, .compress_req,
        .mgmt_stall);
    initial begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task complete_run;
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task lim(input int k, input int n);
        if (k >= n) begin
            error_cnt++;
            complete_run;
        end
    endtask
    task evt(input int p, input int b);
        port_evt[p*RPS_NEVT+b] <= 1'b1;
        @(posedge sys_clk);
        port_evt <= '0;
        @(posedge sys_clk);
    endtask
    task rd(input int p, input logic c, input int cn, input int rc);
        rd_req <= 1'b1;
        rd_port <= p[3:0];
        rd_clear <= c;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        rd_clear <= 1'b0;
        @(negedge sys_clk);
        chk(rd_valid, 1);
        chk(rd_count, cn);
        chk(rd_record, rc);
        @(posedge sys_clk);
    endtask
    task t_counter;
        cnt_sel <= 4'h3;
        rec_mask <= 8'hF0;
        repeat (5) evt(2, 3);
        evt(2, 4);
        evt(2, 1);
        evt(2, 9);
        evt(5, 3);
        rd(2, 1, 5, 8'h0A);
        rd(5, 0, 1, 8'h08);
        rd(2, 0, 0, 0);
        rd(15, 0, 0, 0);
    endtask
    task t_irq;
        int k;
        irq_enable <= 3'h7;
        irq_route_rt <= 3'h2;
        repeat (15) evt(7, 3);
        chk(realtime_event_irq, 0);
        chk(main_irq, 1);
        evt(7, 3);
        k = 0;
        while (realtime_event_irq !== 1'b1 && k < 8) begin
            @(negedge sys_clk);
            k++;
        end
        lim(k, 8);
        chk(realtime_event_irq, 1);
        irq_ack <= 3'h7;
        repeat (2) @(posedge sys_clk);
        irq_ack <= '0;
        repeat (3) @(posedge sys_clk);
        chk(irq_pending, 0);
        port_active <= 12'h060;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(act_port, 5);
        chk(act_any, 1);
        port_active <= '0;
    endtask
    task sym(input logic [1:0] pr);
        int k;
        mch_valid <= 1'b1;
        mch_pair <= pr;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (mch_ready !== 1'b1 && k < 300);
        lim(k, 300);
    endtask
    task frame(input int n, input logic cmp, input int en);
        int b0, d0, k;
        b0 = rps_mgmt_rx_inst.fb.size();
        d0 = rps_mgmt_rx_inst.done_q;
        compress <= cmp;
        slow <= 1'b1;
        rx_src_port <= 4'h4;
        repeat (20) @(posedge sys_clk);
        for (int i = 0; i < n; i++)
            for (int j = 0; j < 8; j++)
                sym((((i + 16) >> j) & 1) ? RPS_MCH_ONE : RPS_MCH_ZERO);
        sym(2'h0);
        mch_valid <= 1'b0;
        k = 0;
        while (rps_mgmt_rx_inst.done_q == d0 && k < 3000) begin
            @(posedge sys_clk);
            k++;
        end
        lim(k, 3000);
        chk(rps_mgmt_rx_inst.fb.size() - b0, en);
        for (int i = 0; i < 14; i++)
            chk(rps_mgmt_rx_inst.fb[b0+i], i + 16);
        if (!cmp) begin
            chk(rps_mgmt_rx_inst.fb[b0+n], 4);
            chk(rps_mgmt_rx_inst.fb[b0+n+3], n);
            chk({rps_mgmt_rx_inst.fb[b0+n+2],
                 rps_mgmt_rx_inst.fb[b0+n+1]} != 16'h0000, 1);
        end
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_counter();
        t_irq();
        frame(20, 1'b0, 27);
        frame(20, 1'b1, 21);
        own_addr <= 48'h1514_1312_1110;
        frame(20, 1'b1, 27);
        complete_run;
    end
endmodule // tb
bind rps_top rps_top_properties #(.NPORTS(NPORTS)) rps_top_properties_inst
    (.*);
